//--- hw/dlsp_pkg.sv
// constants for the two-port serial transmitter (synthesizer and calibration source)
// assumes a single host register port and one serial link clock per design
package dlsp_pkg;
  localparam int NPORT = 2;
  localparam int SYN   = 0;
  localparam int CAL   = 1;

  localparam logic [7:0] A_SYN_LO  = 8'h10;
  localparam logic [7:0] A_SYN_HI  = 8'h14;
  localparam logic [7:0] A_SYN_CTL = 8'h18;
  localparam logic [7:0] A_CAL_LO  = 8'h20;
  localparam logic [7:0] A_CAL_HI  = 8'h24;
  localparam logic [7:0] A_CAL_CTL = 8'h28;

  localparam int B_LOCK   = 17;
  localparam int B_BUSY   = 16;
  localparam int B_LEN_HI = 13;
  localparam int B_LEN_LO = 8;
  localparam int B_REF    = 5;
  localparam int B_CONV   = 4;
  localparam int B_CHAN   = 3;

  localparam int LEN_W  = 6;
  localparam int SIDE_W = 4;
  localparam int ITEM_W = SIDE_W + LEN_W + 64;
  localparam int FIFO_DEPTH = 4;
  // host cycles the link-side reset is stretched by; spans over three link clocks
  localparam logic [4:0] LRST_CNT = 5'h1f;

  localparam logic [31:0] CTL_RST = 32'h0000_0000;
  localparam logic [31:0] WM_SYN  = 32'h0000_3f3f;
  localparam logic [31:0] WM_CAL  = 32'h0000_3f38;
endpackage : dlsp_pkg

//--- hw/dlsp_top.sv
// two serial transmit ports with host registers, word fifo and link-clock engines
// assumes host register strobes on clk; link_clk is free running, unrelated in phase
`timescale 1ns/10ps

module dlsp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
  } dlsp_fifo_s;

  dlsp_fifo_s s;
  dlsp_fifo_s next_s;

  // extra pointer bit tells full from empty
  assign in_ready  = !((s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]));
  assign out_valid = (s.wp != s.rp);
  assign out_data  = s.mem[s.rp[AW-1:0]];

  always_comb begin
    next_s = s;
    if (in_valid && in_ready) begin
      next_s.mem[s.wp[AW-1:0]] = in_data;
      next_s.wp = s.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      next_s.rp = s.rp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : dlsp_fifo

module dlsp_engine
  import dlsp_pkg::*;
(
  input  wire logic              link_clk,
  input  wire logic              sys_rst,
  input  wire logic              req_tgl,
  input  wire logic [ITEM_W-1:0] item,
  output logic                   ack_tgl,
  output logic                   sclk,
  output logic                   en_n,
  output logic                   lane_one,
  output logic                   lane_two
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOW  = 4'b0010,
    ST_HIGH = 4'b0100,
    ST_TAIL = 4'b1000
  } dlsp_state_e;

  typedef struct packed {
    logic             rs1;
    logic             rs2;
    logic             q1;
    logic             q2;
    logic             seen;
    logic             ack;
    dlsp_state_e      st;
    logic [4:0]       cnt;
    logic [LEN_W-1:0] len;
    logic [31:0]      lo;
    logic [31:0]      hi;
    logic             sclk;
    logic             en_n;
    logic             l2;
  } dlsp_eng_s;

  dlsp_eng_s s;
  dlsp_eng_s next_s;
  logic      last;

  assign ack_tgl  = s.ack;
  assign sclk     = s.sclk;
  assign en_n     = s.en_n;
  assign lane_one = s.lo[31];
  assign lane_two = s.l2;

  // length 0 behaves as a single clock; counts above 32 stop at 32
  assign last = (({1'b0, s.cnt} + 6'h01) >= s.len) || (s.cnt == 5'h1f);

  always_comb begin
    next_s     = s;
    next_s.rs1 = sys_rst;
    next_s.rs2 = s.rs1;
    next_s.q1  = req_tgl;
    next_s.q2  = s.q1;
    case (s.st)
      ST_IDLE: begin
        next_s.sclk = 1'b0;
        if (s.q2 != s.seen) begin
          next_s.seen = s.q2;
          next_s.lo   = item[31:0];
          next_s.hi   = item[63:32];
          next_s.len  = item[64 +: LEN_W];
          next_s.cnt  = 5'h00;
          next_s.en_n = 1'b0;
          next_s.st   = ST_LOW;
        end
      end
      ST_LOW: begin
        // rising edge: lane two moves, lane one holds
        next_s.sclk = 1'b1;
        next_s.l2   = s.hi[31];
        next_s.hi   = {s.hi[30:0], 1'b0};
        next_s.st   = ST_HIGH;
      end
      ST_HIGH: begin
        next_s.sclk = 1'b0;
        if (last) begin
          next_s.st = ST_TAIL;
        end else begin
          next_s.lo  = {s.lo[30:0], 1'b0};
          next_s.cnt = s.cnt + 5'h01;
          next_s.st  = ST_LOW;
        end
      end
      ST_TAIL: begin
        next_s.en_n = 1'b1;
        next_s.ack  = ~s.ack;
        next_s.st   = ST_IDLE;
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk) begin
    if (s.rs2) begin
      // the synchroniser keeps sampling so that reset can end
      s      <= '0;
      s.rs1  <= sys_rst;
      s.rs2  <= s.rs1;
      s.st   <= ST_IDLE;
      s.en_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb_link @(posedge link_clk); endclocking
  default disable iff (s.rs2);

  property p_idle_low;
    (s.st == ST_IDLE) |-> !s.sclk;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("clock high while idle");

  property p_en_cover;
    s.sclk |-> !s.en_n ##1 !s.en_n;
  endproperty
  a_en_cover: assert property (p_en_cover) else $error("enable not around clock");

  property p_lane_edges;
    ($rose(s.sclk) |-> $stable(s.lo[31])) and ($fell(s.sclk) |-> $stable(s.l2));
  endproperty
  a_lane_edges: assert property (p_lane_edges) else $error("lane moved on wrong edge");

  property p_msb_first;
    $rose(s.sclk) |-> s.l2 == $past(s.hi[31]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("lane two not msb first");

  property p_count;
    $fell(s.en_n) |-> ##[2:64] (s.st == ST_TAIL);
  endproperty
  a_count: assert property (p_count) else $error("transfer overran 32 clocks");

  c_tail: cover property ((s.st == ST_TAIL) && (s.cnt == 5'h1f));
  c_rise: cover property ($rose(s.sclk));
endmodule : dlsp_engine

module dlsp_top
  import dlsp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       link_clk,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]     reg_rdata,
  output logic            reg_rvalid,
  output logic            synth_sclk,
  output logic            synth_en_n,
  output logic            synth_lane_one,
  output logic            synth_lane_two,
  input  wire logic       synth_lock_in,
  output logic            synth_ref_select,
  output logic            synth_converter_on,
  output logic            synth_chan_sel,
  output logic [2:0]      synth_band_bits,
  output logic            calsrc_sclk,
  output logic            calsrc_en_n,
  output logic            calsrc_lane_one,
  output logic            calsrc_lane_two,
  input  wire logic       calsrc_lock_in,
  output logic            calsrc_ref_select,
  output logic            calsrc_converter_on,
  output logic            calsrc_chan_sel
);
  typedef struct packed {
    logic [NPORT-1:0][31:0]         lo;
    logic [NPORT-1:0][31:0]         hi;
    logic [NPORT-1:0][31:0]         ctl;
    logic [NPORT-1:0]               pend;
    logic [NPORT-1:0]               flight;
    logic [NPORT-1:0]               req;
    logic [NPORT-1:0]               a1;
    logic [NPORT-1:0]               a2;
    logic [NPORT-1:0]               aseen;
    logic [NPORT-1:0]               k1;
    logic [NPORT-1:0]               k2;
    logic [NPORT-1:0][ITEM_W-1:0]   hold;
    logic [NPORT-1:0][SIDE_W-1:0]   side;
    logic [31:0]                    rdata;
    logic                           rvalid;
    logic [4:0]                     lrst_cnt;
    logic                           lrst;
  } dlsp_top_s;

  dlsp_top_s                    s;
  dlsp_top_s                    next_s;
  logic [NPORT-1:0]             lock_in;
  logic [NPORT-1:0]             ack;
  logic [NPORT-1:0]             f_in_rdy;
  logic [NPORT-1:0]             f_ov;
  logic [NPORT-1:0][ITEM_W-1:0] f_od;
  logic [NPORT-1:0][ITEM_W-1:0] f_id;
  logic [NPORT-1:0]             busy;
  logic [NPORT-1:0]             sclk_v;
  logic [NPORT-1:0]             en_n_v;
  logic [NPORT-1:0]             l1_v;
  logic [NPORT-1:0]             l2_v;

  // one-hot {control, high word, low word} hit for port p
  function automatic logic [2:0] sel_of(input logic [7:0] a, input int p);
    if (p == SYN) begin
      sel_of = {a == A_SYN_CTL, a == A_SYN_HI, a == A_SYN_LO};
    end else begin
      sel_of = {a == A_CAL_CTL, a == A_CAL_HI, a == A_CAL_LO};
    end
  endfunction : sel_of

  // calsrc has no band bits; its low control bits stay zero
  function automatic logic [SIDE_W-1:0] side_of(input logic [31:0] c, input int p);
    side_of = (p == SYN) ? c[B_CHAN:0] : {c[B_CHAN], 3'b000};
  endfunction : side_of

  assign lock_in = {calsrc_lock_in, synth_lock_in};

  generate
    for (genvar p = 0; p < NPORT; p++) begin : g_port
      assign f_id[p] = {side_of(s.ctl[p], p), s.ctl[p][B_LEN_HI:B_LEN_LO], s.hi[p], s.lo[p]};
      assign busy[p] = s.pend[p] | f_ov[p] | s.flight[p];

      dlsp_fifo #(
        .W     (ITEM_W),
        .DEPTH (FIFO_DEPTH)
      ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (s.pend[p]),
        .in_ready  (f_in_rdy[p]),
        .in_data   (f_id[p]),
        .out_valid (f_ov[p]),
        .out_ready (!s.flight[p]),
        .out_data  (f_od[p])
      );

      // a short host reset could fall between two slow link edges, so it is stretched
      dlsp_engine u_eng (
        .link_clk (link_clk),
        .sys_rst  (s.lrst),
        .req_tgl  (s.req[p]),
        .item     (s.hold[p]),
        .ack_tgl  (ack[p]),
        .sclk     (sclk_v[p]),
        .en_n     (en_n_v[p]),
        .lane_one (l1_v[p]),
        .lane_two (l2_v[p])
      );
    end
  endgenerate

  always_comb begin
    logic [2:0] sel;
    logic [31:0] wm;
    sel = 3'b000;
    wm  = 32'h0000_0000;
    next_s = s;
    next_s.rvalid = reg_rd;
    next_s.lrst_cnt = (s.lrst_cnt != 5'h00) ? (s.lrst_cnt - 5'h01) : 5'h00;
    next_s.lrst     = (s.lrst_cnt != 5'h00);
    if (reg_rd) begin
      next_s.rdata = 32'h0000_0000;
    end
    for (int p = 0; p < NPORT; p++) begin
      sel = sel_of(reg_addr, p);
      wm  = (p == SYN) ? WM_SYN : WM_CAL;
      next_s.k1[p] = lock_in[p];
      next_s.k2[p] = s.k1[p];
      next_s.a1[p] = ack[p];
      next_s.a2[p] = s.a1[p];
      if (reg_wr && sel[0]) begin
        next_s.lo[p] = reg_wdata;
      end
      if (reg_wr && sel[2]) begin
        next_s.ctl[p] = (s.ctl[p] & ~wm) | (reg_wdata & wm);
      end
      // the fifo push happens a cycle later, from the registered words
      if (reg_wr && sel[1]) begin
        next_s.hi[p]   = reg_wdata;
        next_s.pend[p] = 1'b1;
      end else if (s.pend[p] && f_in_rdy[p]) begin
        next_s.pend[p] = 1'b0;
      end
      if (f_ov[p] && !s.flight[p]) begin
        next_s.hold[p]   = f_od[p];
        next_s.flight[p] = 1'b1;
        next_s.req[p]    = ~s.req[p];
      end
      if (s.a2[p] != s.aseen[p]) begin
        next_s.aseen[p]  = s.a2[p];
        next_s.flight[p] = 1'b0;
        next_s.side[p]   = s.hold[p][ITEM_W-1 -: SIDE_W];
      end
      if (reg_rd && sel[2]) begin
        next_s.rdata = s.ctl[p];
        next_s.rdata[B_BUSY] = busy[p];
        next_s.rdata[B_LOCK] = s.k2[p];
      end else if (reg_rd && sel[1]) begin
        next_s.rdata = s.hi[p];
      end else if (reg_rd && sel[0]) begin
        next_s.rdata = s.lo[p];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s          <= '0;
      s.ctl[SYN] <= CTL_RST;
      s.ctl[CAL] <= CTL_RST;
      s.lrst_cnt <= LRST_CNT;
      s.lrst     <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata           = s.rdata;
  assign reg_rvalid          = s.rvalid;
  assign synth_sclk          = sclk_v[SYN];
  assign synth_en_n          = en_n_v[SYN];
  assign synth_lane_one      = l1_v[SYN];
  assign synth_lane_two      = l2_v[SYN];
  assign synth_ref_select    = s.ctl[SYN][B_REF];
  assign synth_converter_on  = s.ctl[SYN][B_CONV];
  assign synth_chan_sel      = s.side[SYN][3];
  assign synth_band_bits     = s.side[SYN][2:0];
  assign calsrc_sclk         = sclk_v[CAL];
  assign calsrc_en_n         = en_n_v[CAL];
  assign calsrc_lane_one     = l1_v[CAL];
  assign calsrc_lane_two     = l2_v[CAL];
  assign calsrc_ref_select   = s.ctl[CAL][B_REF];
  assign calsrc_converter_on = s.ctl[CAL][B_CONV];
  assign calsrc_chan_sel     = s.side[CAL][3];

  default clocking cb_sys @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_syn_launch;
    (reg_wr && reg_addr == A_SYN_HI) |=> s.pend[SYN] ##1 (f_ov[SYN] || s.flight[SYN]);
  endproperty
  a_syn_launch: assert property (p_syn_launch) else $error("synth write did not launch");

  property p_cal_launch;
    (reg_wr && reg_addr == A_CAL_HI) |=> s.pend[CAL];
  endproperty
  a_cal_launch: assert property (p_cal_launch) else $error("calsrc write did not launch");

  property p_syn_busy;
    (reg_rd && reg_addr == A_SYN_CTL && s.flight[SYN]) |=> s.rdata[B_BUSY];
  endproperty
  a_syn_busy: assert property (p_syn_busy) else $error("synth busy reads zero");

  property p_cal_busy;
    (reg_rd && reg_addr == A_CAL_CTL) |=> s.rdata[B_BUSY] == $past(busy[CAL]);
  endproperty
  a_cal_busy: assert property (p_cal_busy) else $error("calsrc busy bit wrong");

  property p_cal_lock;
    (reg_rd && reg_addr == A_CAL_CTL) |=> s.rdata[B_LOCK] == $past(s.k2[CAL]);
  endproperty
  a_cal_lock: assert property (p_cal_lock) else $error("calsrc lock bit wrong");

  property p_syn_lock;
    (reg_rd && reg_addr == A_SYN_CTL) |=> s.rdata[B_LOCK] == $past(s.k2[SYN]);
  endproperty
  a_syn_lock: assert property (p_syn_lock) else $error("synth lock bit wrong");

  property p_ref_pin;
    (reg_wr && reg_addr == A_SYN_CTL) |=> synth_ref_select == $past(reg_wdata[B_REF]);
  endproperty
  a_ref_pin: assert property (p_ref_pin) else $error("ref select pin not updated");

  property p_band_hold;
    !$stable(s.side[SYN]) |-> $past(s.a2[SYN] != s.aseen[SYN]);
  endproperty
  a_band_hold: assert property (p_band_hold) else $error("synth side pins moved early");

  property p_chan_hold;
    $changed(calsrc_chan_sel) |-> $past(s.a2[CAL] != s.aseen[CAL]);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("calsrc channel moved early");

  property p_end_busy;
    (s.a2[SYN] != s.aseen[SYN]) |=> !s.flight[SYN];
  endproperty
  a_end_busy: assert property (p_end_busy) else $error("busy held after end");

  c_full: cover property (s.pend[SYN] && !f_in_rdy[SYN]);
  c_both: cover property (s.flight[SYN] && s.flight[CAL]);
endmodule : dlsp_top

//--- test/dlsp_far_model.sv
// far-side model of a synthesizer or calibration source serial receiver
// assumes the port keeps its clock low outside frames and drives an active-low enable
`timescale 1ns/10ps

module dlsp_far_model (
  input  wire logic   sclk,
  input  wire logic   en_n,
  input  wire logic   lane_one,
  input  wire logic   lane_two,
  output logic [31:0] lo,
  output logic [31:0] hi,
  output logic [5:0]  n
);
  // a falling enable with the clock low opens a frame; only rises inside it count
  always @(posedge sclk or negedge en_n) begin
    if (!en_n && !sclk) begin
      n <= 6'h00;
    end else if (!en_n) begin
      lo <= {lo[30:0], lane_one};
      n  <= n + 6'h01;
    end
  end

  always @(negedge sclk) begin
    if (!en_n) begin
      hi <= {hi[30:0], lane_two};
    end
  end
endmodule : dlsp_far_model

//--- test/tb_dual_lane_synth_serial_port.sv
// testbench for dlsp_top: host register tasks, one far-side model per port
// assumes dlsp_pkg, the design files and dlsp_far_model are compiled first
`timescale 1ns/10ps

module tb_dual_lane_synth_serial_port;
  import dlsp_pkg::*;
  logic        clk = 0;
  logic        link_clk = 0;
  logic        sys_rst = 1;
  logic        reg_wr = 0;
  logic        reg_rd = 0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic        reg_rvalid;
  wire  [1:0]  sclk, en_n, l1, l2, chan, refs, conv;
  logic        armed = 1'b0;
  logic [1:0]  lock = 2'b00;
  logic [2:0]  band;
  logic [31:0] m_lo [2];
  logic [31:0] m_hi [2];
  logic [5:0]  m_n [2];
  logic [69:0] q [2][$];
  logic [3:0]  cur_sb [2];
  int          num_errors = 0;
  int          compares = 0;

  dlsp_top DUT (.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .synth_sclk(sclk[0]), .synth_en_n(en_n[0]),
    .synth_lane_one(l1[0]), .synth_lane_two(l2[0]), .synth_lock_in(lock[0]),
    .synth_ref_select(refs[0]), .synth_converter_on(conv[0]), .synth_chan_sel(chan[0]),
    .synth_band_bits(band), .calsrc_sclk(sclk[1]), .calsrc_en_n(en_n[1]),
    .calsrc_lane_one(l1[1]), .calsrc_lane_two(l2[1]), .calsrc_lock_in(lock[1]),
    .calsrc_ref_select(refs[1]), .calsrc_converter_on(conv[1]), .calsrc_chan_sel(chan[1]));

  for (genvar i = 0; i < 2; i++) begin : g_far
    dlsp_far_model M (.sclk(sclk[i]), .en_n(en_n[i]), .lane_one(l1[i]), .lane_two(l2[i]),
      .lo(m_lo[i]), .hi(m_hi[i]), .n(m_n[i]));
    // the unknown-to-high step at link reset is not the end of a frame
    always @(posedge en_n[i]) if (armed) seen(i);
  end

  initial begin
    forever #2 clk = ~clk;
  end

  // offset so the link edges never line up with the host clock
  initial begin
    #7.3;
    forever #16 link_clk = ~link_clk;
  end

  task automatic chk(input logic [69:0] got, input logic [69:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] ba(input int p);
    return p ? A_CAL_LO : A_SYN_LO;
  endfunction : ba

  function automatic logic [3:0] sbpin(input int p);
    return p ? {chan[1], 3'h0} : {chan[0], band};
  endfunction : sbpin

  // end of a frame: take the oldest expected word pair and compare
  task automatic seen(input int p);
    logic [69:0] e;
    logic [31:0] m;
    #1;
    if (sys_rst) return;
    chk(sclk[p], 1'b0);
    if (q[p].size() == 0) begin
      chk(1, 0);
      return;
    end
    e = q[p].pop_front();
    m = 32'hffff_ffff >> (32 - e[69:64]);
    chk({m_n[p], m_lo[p] & m, m_hi[p] & m}, e);
  endtask : seen

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    #0.5;
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #0.5;
    reg_wr = 0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    #0.5;
    reg_rd = 1;
    reg_addr = a;
    @(posedge clk);
    #0.5;
    reg_rd = 0;
    chk(reg_rvalid, 1'b1);
    d = reg_rdata;
  endtask : rd

  task automatic wait_idle(input int p);
    logic [31:0] d;
    d = 32'h0001_0000;
    for (int i = 0; i < 2000 && d[B_BUSY] !== 1'b0; i++) rd(ba(p) + 8'h08, d);
    chk(d[B_BUSY], 1'b0);
  endtask : wait_idle

  task automatic launch(input int p, input logic [5:0] n);
    logic [31:0] lo, hi;
    int          k;
    lo = $urandom;
    hi = $urandom;
    k = n == 0 ? 1 : n > 32 ? 32 : n;
    q[p].push_back({6'(k), lo >> (32 - k), hi >> (32 - k)});
    wr(ba(p), lo);
    wr(ba(p) + 8'h04, hi);
  endtask : launch

  // side-band bits rewritten mid-frame must not reach the pins
  task automatic xfer(input int p, input logic [5:0] n);
    logic [5:0]  sb;
    logic [31:0] d;
    sb = $urandom;
    wr(ba(p) + 8'h08, {18'h0, n, 2'h0, sb});
    chk({refs[p], conv[p]}, sb[5:4]);
    launch(p, n);
    rd(ba(p) + 8'h08, d);
    chk(d[B_BUSY], 1'b1);
    wr(ba(p) + 8'h08, {18'h0, n, 2'h0, sb ^ 6'h0f});
    chk(sbpin(p), cur_sb[p]);
    wait_idle(p);
    repeat (8) @(posedge clk);
    cur_sb[p] = p ? {sb[3], 3'h0} : sb[3:0];
    chk(sbpin(p), cur_sb[p]);
  endtask : xfer

  task end_of_test;
    $display("compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #300000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test;
  end

  initial begin
    logic [31:0] d;
    void'($urandom(32'hd690));
    repeat (6) @(posedge clk);
    #0.5;
    sys_rst = 0;
    // the link side reset is stretched; frames are counted only after it
    repeat (40) @(posedge clk);
    #0.5;
    armed = 1'b1;
    cur_sb[0] = 4'h0;
    cur_sb[1] = 4'h0;
    for (int p = 0; p < 2; p++) begin
      lock[p] = 1'($urandom);
      wr(ba(p) + 8'h08, 32'hffff_ffff);
      chk({refs[p], conv[p]}, 2'h3);
      chk(sbpin(p), 4'h0);
      rd(ba(p) + 8'h08, d);
      chk(d, (p ? WM_CAL : WM_SYN) | {14'h0, lock[p], 17'h0});
      wr(ba(p) + 8'h08, 32'h0);
      chk({refs[p], conv[p]}, 2'h0);
      // length zero still sends one clock: lane one 0, lane two 1
      q[p].push_back({6'h01, 32'h0, 32'h1});
      wr(ba(p) + 8'h04, 32'ha5c3_0f96);
      rd(ba(p) + 8'h04, d);
      chk(d, 32'ha5c3_0f96);
      wait_idle(p);
    end
    wr(8'h30, 32'hffff_ffff);
    rd(8'h30, d);
    chk(d, 32'h0);
    $display("test registers done");
    for (int p = 0; p < 2; p++) begin
      xfer(p, 6'h01);
      xfer(p, 6'h20);
      xfer(p, 6'($urandom_range(32, 1)));
    end
    $display("test transfers done");
    for (int p = 0; p < 2; p++) wr(ba(p) + 8'h08, 32'h0000_0300);
    for (int i = 0; i < 4; i++) begin
      launch(0, 6'h03);
      launch(1, 6'h03);
    end
    wait_idle(0);
    wait_idle(1);
    repeat (8) @(posedge clk);
    chk(q[0].size() + q[1].size(), 0);
    $display("test queued launches done");
    end_of_test;
  end
endmodule : tb_dual_lane_synth_serial_port
